// File: common/rtpc_pkg.sv
// ==========================================================================
// shared constants of the radio transaction and power control block
// ==========================================================================
package rtpc_pkg;

    // ======================================================================
    // clock and time
    // ======================================================================
    localparam int CLK_MHZ        = 40;
    localparam int TICK_US        = 1;
    localparam int TICK_CYC       = (TICK_US * CLK_MHZ < 1) ? 1 : TICK_US * CLK_MHZ;
    localparam int SYNTH_SETTLE_US  = 100;
    localparam int SYNTH_SETTLE_CYC = SYNTH_SETTLE_US * CLK_MHZ;
    localparam int OSC_START_US   = 200;
    localparam int OSC_START_CYC  = OSC_START_US * CLK_MHZ;
    localparam int SLEEP_MAX_US   = 35;
    localparam int SLEEP_MAX_CYC  = SLEEP_MAX_US * CLK_MHZ;

    // ======================================================================
    // reset values and encodings
    // ======================================================================
    localparam logic [2:0] END_STATE_SLEEP = 3'h0;
    localparam logic [2:0] END_STATE_RST   = 3'h1;
    localparam logic [2:0] CLKOUT_SEL_RST  = 3'h0;
    localparam logic [7:0] ACK_TMO_RST     = 8'hFF;
    localparam int         CNT_W           = 16;

    // status bit positions inside each group
    localparam int TX_DONE_BIT = 0;
    localparam int TX_TMO_BIT  = 1;
    localparam int RX_DONE_BIT = 0;
    localparam int RX_ACK_BIT  = 1;
    localparam int SYS_OSC_BIT = 0;
    localparam int SYS_BAT_BIT = 1;

    typedef enum {
        SEQ_SLEEP, SEQ_WAKE, SEQ_IDLE, SEQ_SYNTH,
        SEQ_TX_DATA, SEQ_TX_ACKWAIT, SEQ_RX_WAIT, SEQ_RX_ACK
    } rtpc_seq_t;

endpackage : rtpc_pkg

// File: core/rtpc_event_sync.sv
`timescale 1ns/1ps
// ==========================================================================
// toggle crossing for one-cycle events between two clocks
// ==========================================================================
module rtpc_event_sync (
    input  wire logic srcClk,
    input  wire logic srcRst,
    input  wire logic srcPulse,
    input  wire logic dstClk,
    input  wire logic dstRst,
    output logic      dstPulse
);
    logic srcTgl_r;
    logic meta_r;
    logic sync_r;
    logic syncDly_r;

    // events closer than about one destination cycle may cancel out and both be lost
    always_ff @(posedge srcClk) begin
        if (srcRst) srcTgl_r <= 1'b0;
        else if (srcPulse) srcTgl_r <= ~srcTgl_r;
    end

    always_ff @(posedge dstClk) begin
        if (dstRst) begin
            meta_r    <= 1'b0;
            sync_r    <= 1'b0;
            syncDly_r <= 1'b0;
        end else begin
            meta_r    <= srcTgl_r;
            sync_r    <= meta_r;
            syncDly_r <= sync_r;
        end
    end

    assign dstPulse = sync_r ^ syncDly_r;

endmodule : rtpc_event_sync

// File: core/rtpc_clk_div.sv
`timescale 1ns/1ps
// ==========================================================================
// selectable clock output divider
// ==========================================================================
module rtpc_clk_div
    import rtpc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       run,
    input  wire logic [2:0] sel,
    output logic            clkOut
);
    logic [3:0] div_r;
    logic [3:0] half;
    logic       out_r;

    // sel 0..4 gives base/2, /4, /8, /16, /32; larger codes clamp to /32
    always_comb begin
        half = (sel > 3'h4) ? 4'hF : 4'((5'h1 << sel) - 5'h1);
    end

    always_ff @(posedge clk) begin
        if (rst || !run) begin
            div_r <= 4'h0;
            out_r <= 1'b0;
        end else if (div_r >= half) begin
            div_r <= 4'h0;
            out_r <= ~out_r;
        end else begin
            div_r <= div_r + 4'h1;
        end
    end

    assign clkOut = out_r;

endmodule : rtpc_clk_div

// File: core/rtpc_top.sv
`timescale 1ns/1ps
// ==========================================================================
// ==========================================================================
module rtpc_top
    import rtpc_pkg::*;
#(
    parameter int OSC_START = OSC_START_CYC,
    parameter int SYNTH_SETTLE = SYNTH_SETTLE_CYC
) (
    input  wire logic       clk,
    input  wire logic       rst,
    // link side: transaction config writes and tx go, on the serial clock
    input  wire logic       linkClk,
    input  wire logic       linkRst,
    input  wire logic       cfgWrStb,
    input  wire logic       cfgForceEnd,
    input  wire logic [2:0] cfgEndState,
    input  wire logic       txGoStb,
    // configuration
    input  wire logic       rxModeEn,
    input  wire logic [7:0] ackTimeout,
    input  wire logic [1:0] irqEnTx,
    input  wire logic [1:0] irqEnRx,
    input  wire logic [1:0] irqEnSys,
    input  wire logic       irqActHigh,
    input  wire logic       irqOpenDrain,
    input  wire logic [1:0] clrTx,
    input  wire logic [1:0] clrRx,
    input  wire logic       clrSys,
    input  wire logic [2:0] clkOutSel,
    input  wire logic       clkOutOff,
    input  wire logic [2:0] lowBatSel,
    // radio datapath
    input  wire logic       pktSent,
    input  wire logic       pktValid,
    input  wire logic       ackRcvd,
    input  wire logic       rxBufWeIn,
    output logic            rxBufWe,
    output logic            txStart,
    output logic            ackStart,
    output logic            txEn,
    output logic            rxEn,
    output logic            synthEn,
    output logic            oscEn,
    output logic            asleep,
    // analog low battery comparator, asynchronous
    input  wire logic       lowBatCmp,
    output logic            lowBatMonEn,
    output logic [2:0]      lowBatThresh,
    output logic            lowBat,
    // status and pins
    output logic [1:0]      statTx,
    output logic [1:0]      statRx,
    output logic [1:0]      statSys,
    output logic            irqOut,
    output logic            irqOe,
    output logic            clkOut
);

    // ======================================================================
    // link side capture and crossing
    // ======================================================================
    logic       forceReq;
    logic       forceReqSync;
    logic       txGoSync;
    logic [2:0] linkEndState_r;
    logic [2:0] endState_r;

    // end state is held in the link domain; it is stable long before the
    // toggle of the same write reaches the system clock
    always_ff @(posedge linkClk) begin
        if (linkRst) linkEndState_r <= END_STATE_RST;
        else if (cfgWrStb) linkEndState_r <= cfgEndState;
    end

    assign forceReq = cfgWrStb & cfgForceEnd;

    rtpc_event_sync uForceSync (
        .srcClk   (linkClk),
        .srcRst   (linkRst),
        .srcPulse (forceReq),
        .dstClk   (clk),
        .dstRst   (rst),
        .dstPulse (forceReqSync)
    );

    // the host has loaded data and length before this strobe
    rtpc_event_sync uTxGoSync (
        .srcClk   (linkClk),
        .srcRst   (linkRst),
        .srcPulse (txGoStb),
        .dstClk   (clk),
        .dstRst   (rst),
        .dstPulse (txGoSync)
    );

    logic cfgWrSync;

    rtpc_event_sync uCfgSync (
        .srcClk   (linkClk),
        .srcRst   (linkRst),
        .srcPulse (cfgWrStb),
        .dstClk   (clk),
        .dstRst   (rst),
        .dstPulse (cfgWrSync)
    );

    always_ff @(posedge clk) begin
        if (rst) endState_r <= END_STATE_RST;
        else if (cfgWrSync) endState_r <= linkEndState_r;
    end

    // ======================================================================
    // transaction sequencer
    // ======================================================================
    rtpc_seq_t        seq_r;
    rtpc_seq_t        seq_nxt;
    logic             txPend_r;
    logic [CNT_W-1:0] cnt_r;
    logic [7:0]       tick_r;
    logic [7:0]       ackTicks_r;
    logic             cntDone;
    logic             tickHit;
    logic             ackTmo;
    rtpc_seq_t        endTarget;
    logic             oscStableEvt;
    logic             txDoneEvt;
    logic             txTmoEvt;
    logic             rxDoneEvt;
    logic             rxAckEvt;

    function automatic rtpc_seq_t end_target(input logic [2:0] es);
        end_target = (es == END_STATE_SLEEP) ? SEQ_SLEEP : SEQ_IDLE;
    endfunction : end_target

    assign cntDone   = (cnt_r == '0);
    assign tickHit   = (tick_r == 8'(TICK_CYC - 1));
    assign ackTmo    = (seq_r == SEQ_TX_ACKWAIT) && tickHit && (ackTicks_r >= ackTimeout);
    assign endTarget = end_target(endState_r);

    always_comb begin
        seq_nxt = seq_r;
        case (seq_r)
            SEQ_SLEEP: begin
                if (txGoSync || txPend_r || rxModeEn) seq_nxt = SEQ_WAKE;
            end
            SEQ_WAKE: begin
                if (cntDone) seq_nxt = SEQ_IDLE;
            end
            SEQ_IDLE: begin
                if (txGoSync || txPend_r || rxModeEn) seq_nxt = SEQ_SYNTH;
            end
            SEQ_SYNTH: begin
                if (cntDone) seq_nxt = txPend_r ? SEQ_TX_DATA : SEQ_RX_WAIT;
            end
            SEQ_TX_DATA: begin
                if (pktSent) seq_nxt = SEQ_TX_ACKWAIT;
            end
            SEQ_TX_ACKWAIT: begin
                if (ackRcvd || ackTmo) seq_nxt = endTarget;
            end
            SEQ_RX_WAIT: begin
                if (pktValid) seq_nxt = SEQ_RX_ACK;
                else if (!rxModeEn) seq_nxt = endTarget;
            end
            SEQ_RX_ACK: begin
                if (pktSent) seq_nxt = SEQ_RX_WAIT;
            end
            default: seq_nxt = SEQ_IDLE;
        endcase
        // the write is seen about three system cycles after the last serial
        // edge, far inside SLEEP_MAX_CYC
        if (forceReqSync) seq_nxt = end_target(linkEndState_r);
    end

    always_ff @(posedge clk) begin
        if (rst) seq_r <= SEQ_IDLE;
        else seq_r <= seq_nxt;
    end

    // a tx go is held until SEQ_TX_DATA or a forced end clears it; one landing in SEQ_TX_DATA before its last cycle is lost
    always_ff @(posedge clk) begin
        if (rst) txPend_r <= 1'b0;
        else if (txGoSync) txPend_r <= 1'b1;
        else if (forceReqSync || seq_r == SEQ_TX_DATA) txPend_r <= 1'b0;
    end

    // shared down counter for oscillator restart and synthesizer settling
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= '0;
        end else if (seq_nxt == SEQ_WAKE && seq_r != SEQ_WAKE) begin
            cnt_r <= CNT_W'(OSC_START - 1);
        end else if (seq_nxt == SEQ_SYNTH && seq_r != SEQ_SYNTH) begin
            cnt_r <= CNT_W'(SYNTH_SETTLE - 1);
        end else if (!cntDone) begin
            cnt_r <= cnt_r - CNT_W'(1);
        end
    end

    // acknowledgement wait in ticks of TICK_US
    always_ff @(posedge clk) begin
        if (rst || seq_r != SEQ_TX_ACKWAIT) begin
            tick_r     <= 8'h0;
            ackTicks_r <= 8'h0;
        end else if (tickHit) begin
            tick_r     <= 8'h0;
            ackTicks_r <= ackTicks_r + 8'h1;
        end else begin
            tick_r <= tick_r + 8'h1;
        end
    end

    // ======================================================================
    // radio and oscillator controls
    // ======================================================================
    logic txStart_r;
    logic ackStart_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            txStart_r  <= 1'b0;
            ackStart_r <= 1'b0;
        end else begin
            txStart_r  <= (seq_nxt == SEQ_TX_DATA) && (seq_r != SEQ_TX_DATA);
            ackStart_r <= (seq_nxt == SEQ_RX_ACK) && (seq_r != SEQ_RX_ACK);
        end
    end

    assign txStart = txStart_r;
    assign ackStart = ackStart_r;
    assign txEn     = (seq_r == SEQ_TX_DATA) || (seq_r == SEQ_RX_ACK);
    assign rxEn     = (seq_r == SEQ_TX_ACKWAIT) || (seq_r == SEQ_RX_WAIT);
    assign synthEn  = (seq_r == SEQ_SYNTH) || txEn || rxEn;
    assign oscEn    = (seq_r != SEQ_SLEEP);
    assign asleep   = (seq_r == SEQ_SLEEP);
    // ack packets are only sent from a fixed payload and the incoming ACK
    // is consumed by the framer, so both buffers keep their packet
    assign rxBufWe  = rxBufWeIn && (seq_r == SEQ_RX_WAIT);

    // ======================================================================
    // events
    // ======================================================================
    assign oscStableEvt = (seq_r == SEQ_WAKE) && cntDone;
    assign txDoneEvt    = (seq_r == SEQ_TX_ACKWAIT) && ackRcvd;
    assign txTmoEvt     = ackTmo && !ackRcvd;
    assign rxDoneEvt    = (seq_r == SEQ_RX_WAIT) && pktValid;
    assign rxAckEvt     = (seq_r == SEQ_RX_ACK) && pktSent;

    // ======================================================================
    // low battery
    // ======================================================================
    logic batMeta_r;
    logic batSync_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            batMeta_r <= 1'b0;
            batSync_r <= 1'b0;
        end else begin
            batMeta_r <= lowBatCmp;
            batSync_r <= batMeta_r;
        end
    end

    // code 0 is not a level; it is raised to the lowest threshold
    assign lowBatThresh = (lowBatSel == 3'h0) ? 3'h1 : lowBatSel;
    assign lowBatMonEn  = !asleep;
    assign lowBat       = batSync_r && lowBatMonEn;

    // ======================================================================
    // status, sticky except low battery; a set wins over a clear
    // ======================================================================
    logic [1:0] statTx_r;
    logic [1:0] statRx_r;
    logic       oscStat_r;
    logic [1:0] setTx;
    logic [1:0] setRx;

    assign setTx = {txTmoEvt, txDoneEvt};
    assign setRx = {rxAckEvt, rxDoneEvt};

    always_ff @(posedge clk) begin
        if (rst) begin
            statTx_r  <= 2'h0;
            statRx_r  <= 2'h0;
            oscStat_r <= 1'b0;
        end else begin
            statTx_r  <= setTx | (statTx_r & ~clrTx);
            statRx_r  <= setRx | (statRx_r & ~clrRx);
            oscStat_r <= oscStableEvt | (oscStat_r & ~clrSys);
        end
    end

    assign statTx  = statTx_r;
    assign statRx  = statRx_r;
    assign statSys = {lowBat, oscStat_r};

    // ======================================================================
    // interrupt pin
    // ======================================================================
    logic inTxMode;
    logic inRxMode;
    logic irqAct;
    logic irqOut_r;
    logic irqOe_r;

    assign inTxMode = (seq_r == SEQ_TX_DATA) || (seq_r == SEQ_TX_ACKWAIT);
    assign inRxMode = (seq_r == SEQ_RX_WAIT) || (seq_r == SEQ_RX_ACK);

    // enables themselves are never touched; tx and rx are gated by the mode, system enables are not gated
    assign irqAct = (|(statTx_r & irqEnTx) && !inRxMode)
                 || (|(statRx_r & irqEnRx) && !inTxMode)
                 || (|(statSys & irqEnSys));

    always_ff @(posedge clk) begin
        if (rst) begin
            irqOut_r <= 1'b0;
            irqOe_r  <= 1'b0;
        end else begin
            irqOut_r <= irqActHigh ? irqAct : !irqAct;
            irqOe_r  <= irqOpenDrain ? irqAct : 1'b1;
        end
    end

    assign irqOut = irqOut_r;
    assign irqOe  = irqOe_r;

    // ======================================================================
    // clock output
    // ======================================================================
    logic clkRun;

    assign clkRun = !clkOutOff && oscEn && (seq_r != SEQ_WAKE);

    rtpc_clk_div uClkDiv (
        .clk    (clk),
        .rst    (rst),
        .run    (clkRun),
        .sel    (clkOutSel),
        .clkOut (clkOut)
    );

endmodule : rtpc_top

// File: tb/rtpc_top_monitor.sv
`timescale 1ns/1ps
// ==========================================================================
// port checker of the transaction and power control block
// ==========================================================================
module rtpc_top_monitor (
    input logic       clk,
    input logic       rst,
    input logic       linkClk,
    input logic       linkRst,
    input logic       cfgWrStb,
    input logic       cfgForceEnd,
    input logic [2:0] cfgEndState,
    input logic       rxModeEn,
    input logic [1:0] irqEnSys,
    input logic       irqActHigh,
    input logic       irqOpenDrain,
    input logic       pktValid,
    input logic       rxBufWeIn,
    input logic       lowBatCmp,
    input logic       rxBufWe,
    input logic       txStart,
    input logic       ackStart,
    input logic       txEn,
    input logic       rxEn,
    input logic       synthEn,
    input logic       oscEn,
    input logic       asleep,
    input logic       lowBatMonEn,
    input logic       lowBat,
    input logic [1:0] statRx,
    input logic [1:0] statSys,
    input logic       irqOut,
    input logic       irqOe
);
    localparam int SLEEP_LIM = 1400;
    logic       frcTgl_r;
    logic [2:0] frcSync_r;
    logic [10:0] slpCnt_r;
    // ======================================================================
    // force writes to the sleep state carried over to the system clock as a toggle
    // ======================================================================
    always_ff @(posedge linkClk) begin
        if (linkRst)
            frcTgl_r <= 1'b0;
        else if (cfgWrStb && cfgForceEnd && cfgEndState == 3'h0)
            frcTgl_r <= ~frcTgl_r;
    end
    always_ff @(posedge clk) begin
        if (rst)
            frcSync_r <= 3'h0;
        else
            frcSync_r <= {frcSync_r[1:0], frcTgl_r};
    end
    always_ff @(posedge clk) begin
        if (rst || asleep) slpCnt_r <= '0;
        else if (|slpCnt_r || frcSync_r[2] ^ frcSync_r[1]) slpCnt_r <= slpCnt_r + 11'h1;
    end
    // ======================================================================
    // properties
    // ======================================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_sleep_time; slpCnt_r <= SLEEP_LIM; endproperty
    a_sleep_time: assert property (p_sleep_time) else $error("sleep too late");
    property p_osc_off; asleep |-> !oscEn && !txEn && !rxEn && !synthEn; endproperty
    a_osc_off: assert property (p_osc_off) else $error("active while asleep");
    property p_bat_off; (lowBatMonEn != asleep) && !(asleep && lowBat); endproperty
    a_bat_off: assert property (p_bat_off) else $error("monitor on in sleep");
    property p_bat_live; (lowBatCmp && !asleep)[*4] |-> lowBat && statSys[1]; endproperty
    a_bat_live: assert property (p_bat_live) else $error("low battery missed");
    property p_bat_clear; (!lowBatCmp)[*4] |-> !lowBat && !statSys[1]; endproperty
    a_bat_clear: assert property (p_bat_clear) else $error("low battery latched");
    property p_rx_buf; rxBufWe |-> rxBufWeIn && rxEn && !txEn; endproperty
    a_rx_buf: assert property (p_rx_buf) else $error("buffer written off receive");
    property p_start; $rose(txEn) |-> ##[0:1] (txStart || ackStart); endproperty
    a_start: assert property (p_start) else $error("no frame start");
    property p_rx_ack;
        rxModeEn && rxEn && !txEn && pktValid |-> ##[1:3] (txEn && statRx[0]) ##[0:2] ackStart;
    endproperty
    a_rx_ack: assert property (p_rx_ack) else $error("no ack after packet");
    property p_irq_drive; (!irqOpenDrain)[*3] |-> irqOe; endproperty
    a_irq_drive: assert property (p_irq_drive) else $error("push pull not driven");
    property p_rx_mask;
        (rxModeEn && rxEn && !txEn && statRx == 2'h0 && irqEnSys == 2'h0 && $stable(irqActHigh))[*3]
            |-> !(irqOe && irqOut == irqActHigh);
    endproperty
    a_rx_mask: assert property (p_rx_mask) else $error("tx irq in receive");
    property p_wake; $fell(asleep) |-> (!synthEn && !txEn && !rxEn)[*8]; endproperty
    a_wake: assert property (p_wake) else $error("no restart delay");
endmodule : rtpc_top_monitor

bind rtpc_top rtpc_top_monitor u_mon (.*);

// File: tb/rtpc_host_model.sv
`timescale 1ns/1ps
// ==========================================================================
// host side: serial clock only runs inside a frame
// ==========================================================================
module rtpc_host_model (
    output logic       linkClk,
    output logic       linkRst,
    output logic       cfgWrStb,
    output logic       cfgForceEnd,
    output logic [2:0] cfgEndState,
    output logic       txGoStb
);
    initial begin
        linkClk = 1'b0;
        linkRst = 1'b1;
        cfgWrStb = 1'b0;
        txGoStb = 1'b0;
        cfgForceEnd = 1'b0;
        cfgEndState = 3'h1;
    end
    // fields toggle outside the sampled edge so stale values never look valid
    task automatic frame(input logic wr, input logic frc, input logic [2:0] endSt, input logic go);
        for (int i = 0; i < 8; i++) begin
            #7.5 linkClk = 1'b1;
            #7.5 linkClk = 1'b0;
            cfgWrStb = wr && i == 6;
            txGoStb = go && i == 6;
            cfgForceEnd = (i == 6) ? frc : ~cfgForceEnd;
            cfgEndState = (i == 6) ? endSt : ~cfgEndState;
        end
    endtask : frame
    task automatic link_reset();
        frame(1'b0, 1'b0, 3'h1, 1'b0);
        linkRst = 1'b0;
    endtask : link_reset
endmodule : rtpc_host_model

// File: tb/testbench.sv
`timescale 1ns/1ps
// ==========================================================================
// self checking bench of the transaction and power control block
// ==========================================================================
module testbench;
    import rtpc_pkg::*;
    logic       clk, rst = 1'b1, linkClk, linkRst, cfgWrStb, cfgForceEnd, txGoStb;
    logic       rxModeEn = 1'b0, irqActHigh = 1'b0, irqOpenDrain = 1'b0, clrSys = 1'b0;
    logic       clkOutOff = 1'b0, pktSent = 1'b0, pktValid = 1'b0, ackRcvd = 1'b0;
    logic       rxBufWeIn = 1'b0, lowBatCmp = 1'b0, prev;
    logic       rxBufWe, txStart, ackStart, txEn, rxEn, synthEn, oscEn, asleep;
    logic       lowBatMonEn, lowBat, irqOut, irqOe, clkOut;
    logic [1:0] irqEnTx = 2'h0, irqEnRx = 2'h0, irqEnSys = 2'h0, clrTx = 2'h0, clrRx = 2'h0;
    logic [1:0] statTx, statRx, statSys;
    logic [2:0] cfgEndState, clkOutSel = 3'h0, lowBatSel = 3'h1, lowBatThresh;
    logic [7:0] ackTimeout = 8'h03;
    logic [3:0] seenPrev = 4'h0;
    logic [3:0] expQ[$];
    int         err_total = 0, comparisons = 0, sendCnt = 0, cyc = 0, t0, n;
    // released pin rests at the inactive level
    wire        irqPin = irqOe ? irqOut : !irqActHigh;
    wire        irqAct = (irqPin === irqActHigh);

    rtpc_top #(.OSC_START(20), .SYNTH_SETTLE(10)) dut (.*);
    rtpc_host_model host (.*);

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    // ======================================================================
    // radio: frame ends three cycles after it starts
    // ======================================================================
    always @(negedge clk) begin
        pktSent <= (sendCnt == 1);
        sendCnt <= (txStart || ackStart) ? 3 : (sendCnt > 0) ? sendCnt - 1 : 0;
        rxBufWeIn <= 1'($urandom_range(1, 0));
    end
    // ======================================================================
    // status watcher: the bits of statTx, statRx[0] and statSys[0] newly set in one cycle are held together against the oldest note
    // ======================================================================
    always @(negedge clk) begin
        seenPrev <= {statSys[0], statRx[0], statTx};
        if (!rst && ({statSys[0], statRx[0], statTx} & ~seenPrev) != 4'h0)
            chk("event", {4'h0, {statSys[0], statRx[0], statTx} & ~seenPrev},
                {4'h0, (expQ.size() > 0) ? expQ.pop_front() : 4'h0});
    end

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : wrap_up

    initial begin
        #2000000;
        err_total++;
        wrap_up();
    end

    initial begin
        void'($urandom(32'hd57d3cde));
        irqActHigh = 1'($urandom_range(1, 0));
        irqOpenDrain = 1'($urandom_range(1, 0));
        fork
            host.link_reset();
            begin
                repeat (3) @(negedge clk);
                rst = 1'b0;
            end
        join
        @(negedge clk);
        chk("status", {2'h0, statTx, statRx, statSys}, 8'h00);
        chk("irq", {6'h0, irqOe, irqAct}, {6'h0, !irqOpenDrain, 1'b0});
        $display("test reset done");
        // divider ratios, then stopped
        for (int s = 0; s < 6; s++) begin
            clkOutSel = 3'(s);
            clkOutOff = (s == 5);
            repeat (40) @(negedge clk);
            n = 0;
            for (int i = 0; i < 64; i++) begin
                prev = clkOut;
                @(negedge clk);
                n += int'(!prev && clkOut);
            end
            chk("clk rises", 8'(n), (s == 5) ? 8'h00 : 8'(32 >> s));
        end
        clkOutOff = 1'b0;
        $display("test clock out done");
        for (int s = 0; s < 8; s++) begin
            lowBatSel = 3'(s);
            @(negedge clk);
            chk("thresh", {5'h0, lowBatThresh}, (s == 0) ? 8'h01 : 8'(s));
        end
        irqEnSys = 2'h2;
        lowBatCmp = 1'b1;
        repeat (5) @(negedge clk);
        chk("bat on", {6'h0, lowBat, irqAct}, 8'h03);
        lowBatCmp = 1'b0;
        repeat (5) @(negedge clk);
        chk("bat off", {6'h0, lowBat, irqAct}, 8'h00);
        irqEnSys = 2'h0;
        $display("test low battery done");
        // acknowledged transmit, polled with enables off
        expQ.push_back(4'h1);
        host.frame(1'b0, 1'b0, 3'h0, 1'b1);
        for (int i = 0; i < 400 && txStart !== 1'b1; i++) @(negedge clk);
        for (int i = 0; i < 20 && rxEn !== 1'b1; i++) @(negedge clk);
        ackRcvd = 1'b1;
        @(negedge clk);
        ackRcvd = 1'b0;
        repeat (3) @(negedge clk);
        chk("tx end", {5'h0, txEn, rxEn, asleep}, 8'h00);
        $display("test transmit done");
        // receive mode masks the pending transmit status
        irqEnTx = 2'h1;
        irqEnRx = 2'h1;
        rxModeEn = 1'b1;
        for (int i = 0; i < 400 && rxEn !== 1'b1; i++) @(negedge clk);
        repeat (4) @(negedge clk);
        chk("tx masked", {7'h0, irqAct}, 8'h00);
        expQ.push_back(4'h4);
        pktValid = 1'b1;
        @(negedge clk);
        pktValid = 1'b0;
        for (int i = 0; i < 40 && !irqAct; i++) @(negedge clk);
        chk("rx irq", {7'h0, irqAct}, 8'h01);
        clrRx = 2'h3;
        @(negedge clk);
        clrRx = 2'h0;
        repeat (10) @(negedge clk);
        chk("rx read", {7'h0, irqAct}, 8'h00);
        rxModeEn = 1'b0;
        repeat (6) @(negedge clk);
        chk("enable kept", {7'h0, irqAct}, 8'h01);
        clrTx = 2'h3;
        irqEnTx = 2'h0;
        @(negedge clk);
        clrTx = 2'h0;
        $display("test receive done");
        // forced sleep with the comparator tripped
        lowBatCmp = 1'b1;
        host.frame(1'b1, 1'b1, 3'h0, 1'b0);
        for (int i = 0; i < 100 && asleep !== 1'b1; i++) @(negedge clk);
        chk("asleep", {5'h0, asleep, oscEn, lowBat}, 8'h04);
        lowBatCmp = 1'b0;
        $display("test sleep done");
        // wake on go, ack timeout, automatic sleep
        ackTimeout = 8'($urandom_range(4, 1));
        expQ.push_back(4'h8);
        expQ.push_back(4'h2);
        host.frame(1'b1, 1'b0, 3'h0, 1'b0);
        host.frame(1'b0, 1'b0, 3'h0, 1'b1);
        for (int i = 0; i < 400 && txStart !== 1'b1; i++) @(negedge clk);
        for (int i = 0; i < 20 && rxEn !== 1'b1; i++) @(negedge clk);
        t0 = cyc;
        for (int i = 0; i < 400 && asleep !== 1'b1; i++) @(negedge clk);
        n = cyc - t0;
        chk("ack wait", {7'h0, n > (ackTimeout - 1) * 40 && n <= ackTimeout * 40 + 44}, 8'h01);
        chk("auto sleep", {7'h0, asleep}, 8'h01);
        clrSys = 1'b1;
        @(negedge clk);
        clrSys = 1'b0;
        chk("osc clear", {7'h0, statSys[0]}, 8'h00);
        $display("test timeout done");
        chk("notes left", 8'(expQ.size()), 8'h00);
        wrap_up();
    end
endmodule : testbench
